// file: amm_pkg.sv
package amm_pkg;
  localparam int AMM_NCH = 64;
  localparam int AMM_NSRC = 128;
  localparam int AMM_NPAIR = 32;
  localparam int AMM_SW = 24;
  localparam int AMM_ACCW = 32;
  localparam int AMM_GW = 16;
  localparam int AMM_AW = 15;
  localparam logic [23:0] AMM_FS = 24'h7f_ffff;
  localparam logic [23:0] AMM_NEG_FS = 24'h80_0000;
  localparam logic [15:0] AMM_UNITY = 16'h8000;
  localparam logic [7:0] AMM_PAN_FULL = 8'hff;
  localparam int AMM_CLK_KHZ = 125000;
  localparam int AMM_METER_MS = 500;
  localparam int AMM_METER_CYC = AMM_METER_MS * AMM_CLK_KHZ;
  localparam int AMM_RMS_SHIFT = 14;
  localparam logic [6:0] AMM_NACT_SINGLE = 7'h40;
  localparam logic [6:0] AMM_NACT_DOUBLE = 7'h20;
  localparam logic [6:0] AMM_NACT_QUAD = 7'h10;
  localparam logic [1:0] AMM_RATE_SINGLE = 2'h0;
  localparam logic [1:0] AMM_RATE_DOUBLE = 2'h1;
  localparam logic [14:0] AMM_CTRL = 15'h0000;
  localparam logic [14:0] AMM_STATUS = 15'h0004;
  localparam logic [14:0] AMM_MUTE_BASE = 15'h0010;
  localparam logic [14:0] AMM_SOLO_BASE = 15'h0020;
  localparam logic [14:0] AMM_LOOP_BASE = 15'h0030;
  localparam logic [14:0] AMM_LEVEL_BASE = 15'h0100;
  localparam logic [14:0] AMM_SPEAK_BASE = 15'h0200;
  localparam logic [14:0] AMM_RMS_BASE = 15'h0400;
  localparam logic [14:0] AMM_OPEAK_BASE = 15'h0600;
  localparam logic [14:0] AMM_ROUTE_BASE = 15'h4000;
  typedef struct packed {
    logic [7:0] pan;
    logic [15:0] gain;
  } amm_route_t;
  typedef struct packed {
    logic [4:0] mon;
    logic [1:0] rate;
  } amm_ctrl_t;
endpackage : amm_pkg

// file: amm_lane.sv
`timescale 1ns/1ps
`default_nettype none
module amm_lane import amm_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic acc_en,
  input wire logic excl,
  input wire logic signed [AMM_SW-1:0] x,
  input wire amm_route_t route,
  input wire logic [AMM_GW-1:0] level_l,
  input wire logic [AMM_GW-1:0] level_r,
  output logic signed [AMM_SW-1:0] out_l,
  output logic signed [AMM_SW-1:0] out_r
);
  logic signed [AMM_ACCW-1:0] acc_l;
  logic signed [AMM_ACCW-1:0] acc_r;
  logic signed [AMM_ACCW-1:0] next_acc_l;
  logic signed [AMM_ACCW-1:0] next_acc_r;
  logic signed [40:0] prod;
  logic signed [35:0] part_l;
  logic signed [35:0] part_r;

  function automatic logic signed [31:0] sat_add(input logic signed [31:0] a,
                                                 input logic signed [31:0] b);
    logic signed [32:0] s;
    s = {a[31], a} + {b[31], b};
    if (s[32] != s[31]) begin
      return s[32] ? 32'h8000_0000 : 32'h7fff_ffff;
    end
    return s[31:0];
  endfunction : sat_add

  function automatic logic signed [23:0] sat_out(input logic signed [48:0] v);
    logic signed [33:0] s;
    s = v[48:15];
    if (s > $signed(34'h0_007f_ffff)) begin
      return AMM_FS;
    end
    if (s < $signed(34'h3_ff80_0000)) begin
      return AMM_NEG_FS;
    end
    return s[23:0];
  endfunction : sat_out

  always_comb begin
    // zero gain yields a zero product, so a routing at full attenuation adds nothing
    prod = x * $signed({1'b0, route.gain});
    part_l = $signed(prod[40:15]) * $signed({1'b0, AMM_PAN_FULL - route.pan});
    part_r = $signed(prod[40:15]) * $signed({1'b0, route.pan});
    next_acc_l = acc_l;
    next_acc_r = acc_r;
    if (clear) begin
      next_acc_l = '0;
      next_acc_r = '0;
    end else if (acc_en && !excl) begin
      next_acc_l = sat_add(acc_l, {{4{part_l[35]}}, part_l[35:8]});
      next_acc_r = sat_add(acc_r, {{4{part_r[35]}}, part_r[35:8]});
    end
    out_l = sat_out(acc_l * $signed({1'b0, level_l}));
    out_r = sat_out(acc_r * $signed({1'b0, level_r}));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_l <= '0;
      acc_r <= '0;
    end else begin
      acc_l <= next_acc_l;
      acc_r <= next_acc_r;
    end
  end
endmodule : amm_lane
`default_nettype wire

// file: amm_mixer.sv
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module amm_mixer import amm_pkg::*; #(
  parameter int METER_CYC = AMM_METER_CYC,
  parameter int RMS_SHIFT = AMM_RMS_SHIFT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic src_valid,
  input wire logic signed [AMM_SW-1:0] src_data,
  output logic src_ready,
  output logic mix_valid,
  output logic [AMM_NCH-1:0][AMM_SW-1:0] mix_data,
  output logic [AMM_NCH-1:0][AMM_SW-1:0] rec_data
);
  amm_ctrl_t ctrl, next_ctrl, act_ctrl;
  logic [AMM_NSRC-1:0] mute, next_mute, act_mute;
  logic [AMM_NSRC-1:0] solo, next_solo, act_solo;
  logic [AMM_NCH-1:0] loopb, next_loopb, act_loop;
  logic [AMM_GW-1:0] level [AMM_NCH];
  logic [AMM_GW-1:0] act_level [AMM_NCH];
  amm_route_t route_mem [AMM_NSRC][AMM_NPAIR];
  logic signed [AMM_SW-1:0] in_hold [AMM_NCH];
  logic signed [AMM_SW-1:0] lane_out [AMM_NCH];
  logic [24:0] peak_live [AMM_NSRC];
  logic [24:0] peak_disp [AMM_NSRC];
  logic [31:0] rms [AMM_NSRC];
  logic [24:0] opeak_live [AMM_NCH];
  logic [24:0] opeak_disp [AMM_NCH];
  logic [6:0] s_idx, next_s_idx;
  logic fin, next_fin;
  logic [15:0] frame_cnt, next_frame_cnt;
  logic [31:0] meter_cnt, next_meter_cnt;
  logic refresh;
  logic fire, src_act, any_solo;
  logic signed [AMM_SW-1:0] x_eff;
  logic [24:0] src_pk;
  logic [31:0] src_sq;
  logic signed [47:0] sq_full;
  logic signed [32:0] rms_step;
  logic wr_pend, next_wr_pend;
  logic [AMM_AW-1:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  logic addr_ok;
  logic [AMM_AW-1:0] ra;

  function automatic logic hit(input logic [AMM_AW-1:0] a, input logic [AMM_AW-1:0] base,
                               input int words);
    // compared at 32 bits: the routing region ends past the 15-bit address space
    return (a >= base) && (32'(a) < 32'(base) + 32'(words * 4));
  endfunction : hit

  function automatic logic [6:0] nact_of(input logic [1:0] r);
    unique case (r)
      AMM_RATE_SINGLE: return AMM_NACT_SINGLE;
      AMM_RATE_DOUBLE: return AMM_NACT_DOUBLE;
      default: return AMM_NACT_QUAD;
    endcase
  endfunction : nact_of

  // magnitude with the overload flag in bit 24
  function automatic logic [24:0] peak_of(input logic signed [AMM_SW-1:0] v);
    logic [23:0] m;
    m = v[23] ? ((v == AMM_NEG_FS) ? AMM_FS : 24'(-v)) : v;
    return {m == AMM_FS, m};
  endfunction : peak_of

  function automatic logic [24:0] pk_max(input logic [24:0] a, input logic [24:0] b);
    return {a[24] | b[24], (a[23:0] > b[23:0]) ? a[23:0] : b[23:0]};
  endfunction : pk_max

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign src_ready = !fin;
  assign fire = src_valid && src_ready;
  assign any_solo = |act_solo;
  assign refresh = meter_cnt == 32'(METER_CYC - 1);
  assign addr_ok = hsel && hready && htrans[1];
  assign ra = haddr[AMM_AW-1:0];

  always_comb begin
    // channels above the rate's count are skipped; their stored settings stay
    src_act = fire && ({1'b0, s_idx[5:0]} < nact_of(act_ctrl.rate));
    x_eff = act_mute[s_idx] ? '0 : src_data;
    src_pk = peak_of(src_data);
    sq_full = src_data * src_data;
    src_sq = sq_full[46:15];
    rms_step = $signed({1'b0, src_sq}) - $signed({1'b0, rms[s_idx]});
  end

  // one lane per output pair, each summing every source within the rate's count with its own gain and pan; the monitor pair skips non-solo sources under solo
  for (genvar p = 0; p < AMM_NPAIR; p++) begin : g_lane
    logic pair_on;
    logic excl;
    assign pair_on = 7'(2 * p) < nact_of(act_ctrl.rate);
    assign excl = any_solo && (act_ctrl.mon == 5'(p)) && !act_solo[s_idx];
    amm_lane u_lane (
      .hclk(hclk),
      .hresetn(hresetn),
      .clear(fin),
      .acc_en(src_act),
      .excl(excl),
      .x(x_eff),
      .route(route_mem[s_idx][p]),
      .level_l(pair_on ? act_level[2 * p] : 16'h0000),
      .level_r(pair_on ? act_level[2 * p + 1] : 16'h0000),
      .out_l(lane_out[2 * p]),
      .out_r(lane_out[2 * p + 1])
    );
  end

  always_comb begin
    next_s_idx = fire ? s_idx + 7'h01 : s_idx;
    next_fin = fire && (s_idx == 7'h7f);
    next_frame_cnt = fin ? frame_cnt + 16'h0001 : frame_cnt;
    next_meter_cnt = refresh ? 32'h0000_0000 : meter_cnt + 32'h0000_0001;
    next_wr_pend = addr_ok && hwrite;
    next_wr_addr = addr_ok ? ra : wr_addr;
    next_ctrl = ctrl;
    next_mute = mute;
    next_solo = solo;
    next_loopb = loopb;
    if (wr_pend) begin
      if (wr_addr == AMM_CTRL) begin
        next_ctrl = hwdata[6:0];
      end
      if (hit(wr_addr, AMM_MUTE_BASE, 4)) begin
        next_mute[wr_addr[3:2] * 32 +: 32] = hwdata;
      end
      if (hit(wr_addr, AMM_SOLO_BASE, 4)) begin
        next_solo[wr_addr[3:2] * 32 +: 32] = hwdata;
      end
      if (hit(wr_addr, AMM_LOOP_BASE, 2)) begin
        next_loopb[wr_addr[2] * 32 +: 32] = hwdata;
      end
    end
    next_hrdata = hrdata;
    if (addr_ok && !hwrite) begin
      next_hrdata = 32'h0000_0000;
      if (ra == AMM_CTRL) begin
        next_hrdata = {25'h000_0000, ctrl};
      end
      if (ra == AMM_STATUS) begin
        next_hrdata = {14'h0000, |mute, |solo, frame_cnt};
      end
      if (hit(ra, AMM_MUTE_BASE, 4)) begin
        next_hrdata = mute[ra[3:2] * 32 +: 32];
      end
      if (hit(ra, AMM_SOLO_BASE, 4)) begin
        next_hrdata = solo[ra[3:2] * 32 +: 32];
      end
      if (hit(ra, AMM_LOOP_BASE, 2)) begin
        next_hrdata = loopb[ra[2] * 32 +: 32];
      end
      if (hit(ra, AMM_LEVEL_BASE, AMM_NCH)) begin
        next_hrdata = {16'h0000, level[ra[7:2]]};
      end
      if (hit(ra, AMM_SPEAK_BASE, AMM_NSRC)) begin
        next_hrdata = {7'h00, peak_disp[ra[8:2]]};
      end
      if (hit(ra, AMM_RMS_BASE, AMM_NSRC)) begin
        next_hrdata = rms[ra[8:2]];
      end
      if (hit(ra, AMM_OPEAK_BASE, AMM_NCH)) begin
        next_hrdata = {7'h00, opeak_disp[ra[7:2]]};
      end
      if (hit(ra, AMM_ROUTE_BASE, AMM_NSRC * AMM_NPAIR)) begin
        next_hrdata = {8'h00, route_mem[ra[13:7]][ra[6:2]]};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_idx <= '0;
      fin <= 1'b0;
      frame_cnt <= '0;
      meter_cnt <= '0;
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= '0;
      ctrl <= '0;
      mute <= '0;
      solo <= '0;
      loopb <= '0;
    end else begin
      s_idx <= next_s_idx;
      fin <= next_fin;
      frame_cnt <= next_frame_cnt;
      meter_cnt <= next_meter_cnt;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      ctrl <= next_ctrl;
      mute <= next_mute;
      solo <= next_solo;
      loopb <= next_loopb;
    end
  end

  // storage written by software; routing words update one routing at a time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int o = 0; o < AMM_NCH; o++) begin
        level[o] <= AMM_UNITY;
      end
      for (int s = 0; s < AMM_NSRC; s++) begin
        for (int p = 0; p < AMM_NPAIR; p++) begin
          route_mem[s][p] <= '0;
        end
      end
    end else if (wr_pend) begin
      if (hit(wr_addr, AMM_LEVEL_BASE, AMM_NCH)) begin
        level[wr_addr[7:2]] <= hwdata[15:0];
      end
      if (hit(wr_addr, AMM_ROUTE_BASE, AMM_NSRC * AMM_NPAIR)) begin
        route_mem[wr_addr[13:7]][wr_addr[6:2]] <= hwdata[23:0];
      end
    end
  end

  // frame end: outputs, record path and the settings for the next frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mix_valid <= 1'b0;
      mix_data <= '0;
      rec_data <= '0;
      act_ctrl <= '0;
      act_mute <= '0;
      act_solo <= '0;
      act_loop <= '0;
      for (int o = 0; o < AMM_NCH; o++) begin
        act_level[o] <= AMM_UNITY;
        in_hold[o] <= '0;
      end
    end else begin
      mix_valid <= fin;
      if (fire && !s_idx[6]) begin
        in_hold[s_idx[5:0]] <= src_data;
      end
      if (fin) begin
        act_ctrl <= ctrl;
        act_mute <= mute;
        act_solo <= solo;
        act_loop <= loopb;
        for (int o = 0; o < AMM_NCH; o++) begin
          act_level[o] <= level[o];
          mix_data[o] <= lane_out[o];
          rec_data[o] <= act_loop[o] ? lane_out[o] : in_hold[o];
        end
      end
    end
  end

  // meters: a new sample wins over the refresh clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int s = 0; s < AMM_NSRC; s++) begin
        peak_live[s] <= '0;
        peak_disp[s] <= '0;
        rms[s] <= '0;
      end
      for (int o = 0; o < AMM_NCH; o++) begin
        opeak_live[o] <= '0;
        opeak_disp[o] <= '0;
      end
    end else begin
      for (int s = 0; s < AMM_NSRC; s++) begin
        if (fire && (s_idx == 7'(s))) begin
          peak_live[s] <= refresh ? src_pk : pk_max(peak_live[s], src_pk);
          rms[s] <= 32'($signed({1'b0, rms[s]}) + (rms_step >>> RMS_SHIFT));
        end else if (refresh) begin
          peak_live[s] <= '0;
        end
        if (refresh) begin
          peak_disp[s] <= peak_live[s];
        end
      end
      for (int o = 0; o < AMM_NCH; o++) begin
        if (fin) begin
          opeak_live[o] <= refresh ? peak_of(lane_out[o])
                                   : pk_max(opeak_live[o], peak_of(lane_out[o]));
        end else if (refresh) begin
          opeak_live[o] <= '0;
        end
        if (refresh) begin
          opeak_disp[o] <= opeak_live[o];
        end
      end
    end
  end
endmodule : amm_mixer
`default_nettype wire

// file: amm_placeholder_note_not_used.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: amm_mixer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module amm_mixer_properties import amm_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic src_valid,
  input wire logic src_ready,
  input wire logic mix_valid,
  input wire logic [AMM_NCH-1:0][AMM_SW-1:0] mix_data,
  input wire logic [AMM_NCH-1:0][AMM_SW-1:0] rec_data
);
  logic [6:0] slot;
  logic rd_go;
  assign rd_go = hsel && htrans[1] && !hwrite;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot <= 7'h00;
    end else if (src_valid && src_ready) begin
      slot <= slot + 7'h01;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_last_take;
    src_valid && src_ready && slot == 7'h7f;
  endsequence
  sequence s_frame_out;
    !src_ready ##1 (src_ready && mix_valid);
  endsequence
  a_frame_end: assert property (s_last_take |=> s_frame_out)
    else $error("frame end timing wrong");
  a_stall_cause: assert property (!src_ready |-> $past(src_valid && src_ready && slot == 7'h7f))
    else $error("stall without frame end");
  a_valid_pulse: assert property (mix_valid |=> !mix_valid)
    else $error("mix valid longer than one cycle");
  a_mix_hold: assert property (!mix_valid |-> $stable(mix_data))
    else $error("mix data changed between frames");
  a_rec_hold: assert property (!mix_valid |-> $stable(rec_data))
    else $error("record data changed between frames");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
  a_unmapped_zero: assert property ((rd_go && haddr[14:0] == 15'h0008) |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_over_flag: assert property ((rd_go && haddr[14:11] == 4'h0 && haddr[9]) |=>
    (hrdata[31:25] == 7'h00 && hrdata[24] == (hrdata[23:0] == 24'h7f_ffff)))
    else $error("over flag does not match peak");
endmodule : amm_mixer_properties
`default_nettype wire

// file: amm_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module amm_src_model import amm_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic slow,
  input wire logic [127:0][AMM_SW-1:0] frame,
  input wire logic src_ready,
  output logic src_valid,
  output logic signed [AMM_SW-1:0] src_data
);
  logic r;
  initial begin
    src_valid = 1'b0;
    src_data = 24'h00_0000;
  end
  always @(posedge hclk) begin
    if (go && hresetn) begin
      for (int i = 0; i < 128; i++) begin
        if (slow) begin
          src_valid <= 1'b0;
          src_data <= ~src_data;
          @(posedge hclk);
        end
        src_valid <= 1'b1;
        src_data <= frame[i];
        r = 1'b0;
        while (!r) begin
          @(negedge hclk) r = src_ready;
          @(posedge hclk);
        end
      end
      // idle line shows inverted data, never the last sample
      src_valid <= 1'b0;
      src_data <= ~src_data;
    end
  end
endmodule : amm_src_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import amm_pkg::*; ;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, slow = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic hreadyout, hresp, src_ready, src_valid, mix_valid;
  logic signed [AMM_SW-1:0] src_data;
  logic [AMM_NCH-1:0][AMM_SW-1:0] mix_data, rec_data;
  logic [127:0][AMM_SW-1:0] frame = '0;
  int error_cnt = 0, tests_run = 0, rate = 0, mon = 0, g[128][32], pn[128][32], lvl[64];
  bit mute[128], solo[128], loopb[64];
  bit [31:0] seed = 32'h0001_1507;
  longint em[64];
  always #4 hclk = ~hclk;
  amm_mixer #(.METER_CYC(300), .RMS_SHIFT(2)) u_amm_mixer (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
    .mix_valid(mix_valid), .mix_data(mix_data), .rec_data(rec_data));
  amm_src_model u_amm_src_model (.hclk(hclk), .hresetn(hresetn), .go(go), .slow(slow),
    .frame(frame), .src_ready(src_ready), .src_valid(src_valid), .src_data(src_data));
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic to_fail();
    error_cnt++;
    $display("unexpected wait exp done got timeout");
    complete_run();
  endtask : to_fail
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 50) to_fail();
    end while (hreadyout !== 1'b1);
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : ahb
  task automatic route(input int s, input int p, input int gn, input int pa);
    g[s][p] = gn & 32'h0000_ffff;
    pn[s][p] = pa & 32'h0000_00ff;
    ahb(1'b1, 32'(AMM_ROUTE_BASE) + 4 * (s * 32 + p), 32'(pn[s][p] * 65536 + g[s][p]));
  endtask : route
  task automatic masks();
    logic [31:0] m, sl, lp;
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 32; i++) begin
        m[i] = mute[32 * k + i];
        sl[i] = solo[32 * k + i];
        lp[i] = loopb[(32 * k + i) % 64];
      end
      ahb(1'b1, 32'(AMM_MUTE_BASE) + 4 * k, m);
      ahb(1'b1, 32'(AMM_SOLO_BASE) + 4 * k, sl);
      if (k < 2) ahb(1'b1, 32'(AMM_LOOP_BASE) + 4 * k, lp);
    end
  endtask : masks
  task automatic mdl();
    longint acc[64], x, c;
    int na;
    bit sany;
    na = rate == 0 ? 64 : rate == 1 ? 32 : 16;
    sany = 1'b0;
    foreach (solo[s]) sany |= solo[s];
    foreach (acc[o]) acc[o] = 0;
    for (int s = 0; s < 128; s++) begin
      x = signed'(frame[s]);
      if (mute[s] || s % 64 >= na) continue;
      for (int p = 0; p < 32; p++) begin
        if (sany && !solo[s] && p == mon) continue;
        c = (x * g[s][p]) >>> 15;
        acc[2 * p] += (c * (255 - pn[s][p])) >>> 8;
        acc[2 * p + 1] += (c * pn[s][p]) >>> 8;
      end
    end
    for (int o = 0; o < 64; o++) begin
      x = (acc[o] * lvl[o]) >>> 15;
      x = x > 8388607 ? 8388607 : x < -8388608 ? -8388608 : x;
      em[o] = o >= na ? 0 : x;
    end
  endtask : mdl
  task automatic run_frame(input bit c);
    int n;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
      if (n > 600) to_fail();
    end while (mix_valid !== 1'b1);
    if (c) begin
      mdl();
      for (int o = 0; o < 64; o++) begin
        chk($sformatf("mix%0d", o), 32'(em[o][23:0]), 32'(mix_data[o]));
        chk($sformatf("rec%0d", o), 32'(loopb[o] ? em[o][23:0] : frame[o]),
          32'(rec_data[o]));
      end
    end
    @(posedge hclk);
  endtask : run_frame
  task automatic poll(input logic [31:0] a, input logic [31:0] e, input string n);
    int k;
    k = 0;
    run_frame(1'b0);
    do begin
      ahb(1'b0, a, 32'h0000_0000);
      k++;
      if (k > 400) to_fail();
    end while (rd === 32'h0000_0000);
    chk(n, e, rd);
  endtask : poll
  initial begin
    foreach (lvl[o]) lvl[o] = 32'h0000_8000;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'(AMM_CTRL), 32'h0000_0000);
    chk("ctrl", 32'h0000_0000, rd);
    ahb(1'b0, 32'(AMM_LEVEL_BASE) + 28, 32'h0000_0000);
    chk("level7", 32'h0000_8000, rd);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    route(5, 0, 32'h0000_8000, 0);
    lvl[0] = 32'h0000_4000;
    ahb(1'b1, 32'(AMM_LEVEL_BASE), 32'h0000_4000);
    frame[5] = 24'h7f_ffff;
    frame[70] = 24'h00_1000;
    run_frame(1'b0);
    run_frame(1'b1);
    poll(32'(AMM_SPEAK_BASE) + 20, 32'h017f_ffff, "peak5");
    poll(32'(AMM_SPEAK_BASE) + 280, 32'h0000_1000, "peak70");
    poll(32'(AMM_OPEAK_BASE), 32'(em[0]), "opeak0");
    ahb(1'b0, 32'(AMM_RMS_BASE) + 20, 32'h0000_0000);
    chk("rms5", 32'h0000_0001, 32'(rd != 32'h0000_0000));
    for (int i = 0; i < 64; i++) route(64 + i, i / 2, 32'h0000_8000, i % 2 * 255);
    for (int i = 0; i < 12; i++) route(rnd() % 128, rnd() % 32, rnd(), rnd());
    for (int p = 1; p < 32; p += 10) route(3, p, 32'h0000_1000 * p, 32'h0000_0040);
    foreach (frame[s]) frame[s] = 24'(rnd() >> 8);
    slow <= 1'b1;
    run_frame(1'b0);
    run_frame(1'b1);
    slow <= 1'b0;
    ahb(1'b0, 32'(AMM_ROUTE_BASE) + 4 * (3 * 32 + 11), 32'h0000_0000);
    chk("route3_11", 32'h0040_b000, rd);
    mute[66] = 1'b1;
    solo[3] = 1'b1;
    solo[100] = 1'b1;
    loopb[5] = 1'b1;
    loopb[40] = 1'b1;
    mon = 1;
    masks();
    ahb(1'b1, 32'(AMM_CTRL), 32'h0000_0004);
    run_frame(1'b0);
    run_frame(1'b1);
    ahb(1'b0, 32'(AMM_MUTE_BASE) + 8, 32'h0000_0000);
    chk("mute2", 32'h0000_0004, rd);
    ahb(1'b0, 32'(AMM_STATUS), 32'h0000_0000);
    chk("status", 32'h0000_0003, 32'(rd[17:16]));
    for (int v = 0; v < 2; v++) begin
      foreach (frame[s]) frame[s] = v ? 24'h80_0000 : 24'h7f_ffff;
      run_frame(1'b0);
      run_frame(1'b1);
    end
    for (int r = 1; r < 5; r++) begin
      rate = r % 4;
      ahb(1'b1, 32'(AMM_CTRL), 32'(rate + 4));
      run_frame(1'b0);
      run_frame(1'b1);
    end
    complete_run();
  end
endmodule : tb_top
bind amm_mixer amm_mixer_properties u_amm_mixer_properties (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .haddr(haddr), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .src_valid(src_valid), .src_ready(src_ready),
  .mix_valid(mix_valid), .mix_data(mix_data), .rec_data(rec_data));
`default_nettype wire
